// >>> core/pss_delay_timer.sv
module pss_delay_timer
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // timing
  input wire logic tick,
  input wire logic run,
  input wire logic [TIME_W-1:0] limit,
  // result
  output logic done
);

  logic [TIME_W-1:0] count_r;

  // counts ticks while the condition holds, clears when it lapses
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count_r <= '0; // [R15]
    end else if (tick && (count_r < limit)) begin
      count_r <= count_r + 1'b1;
    end
  end

  // expiry only while the condition still holds
  assign done = run && (count_r >= limit);

endmodule // pss_delay_timer

// >>> core/pss_pkg.sv
// Notes on behaviour
// [R1] Two modes: variable pump alone, or with one fixed-speed auxiliary pump.
// [R2] Auxiliary pump is switched on and off by a dedicated output pin.
// [R3] Start and stop thresholds on the frequency reference form a hysteresis.
// [R4] Above start frequency, wait start delay; start only if still above.
// [R5] On start, ramp variable pump down to stop frequency over start ramp.
// [R6] Below stop frequency, wait stop delay; stop only if still below.
// [R7] On stop, ramp variable pump up to start frequency over stop ramp.
// [R8] Near top speed with feedback under low limit minus 2%, start delay.
// [R9] Feedback still under low limit plus 3% at expiry enters fallback.
// [R10] Freewheel fallback coasts the motor and shows the freewheel fault code.
// [R11] Fixed fallback runs at fallback frequency and shows fixed speed code.
// [R12] Either fallback returns to regulation once feedback exceeds limit plus 3%.
// [R13] With auxiliary pump, supervise feedback only while both pumps run.
// [R14] Delays and ramps range 0 to 999.9 s, two seconds after reset.
// [R15] A delay whose condition lapses is cancelled and restarts from zero.
package pss_pkg;

  // data widths: frequency in 0.1 Hz, feedback in 0.1 %, time in 0.1 s
  localparam int FREQ_W = 16;
  localparam int TIME_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 4;

  // timing: one tick of the delay timers is a tenth of a second
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 100_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // time limits in tenths of a second
  localparam logic [TIME_W-1:0] TIME_MAX = 16'h270F;
  localparam logic [TIME_W-1:0] TIME_RST = 16'h0014;

  // feedback offsets in tenths of a percent
  localparam logic [FREQ_W-1:0] FB_TRIP_OFS = 16'h0014;
  localparam logic [FREQ_W-1:0] FB_CLEAR_OFS = 16'h001E;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_START_FREQ = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STOP_FREQ = 8'h08;
  localparam logic [ADDR_W-1:0] REG_START_DELAY = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_START_RAMP = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STOP_DELAY = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STOP_RAMP = 8'h18;
  localparam logic [ADDR_W-1:0] REG_TOP_SPEED = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_TOP_MARGIN = 8'h20;
  localparam logic [ADDR_W-1:0] REG_FB_LIMIT = 8'h24;
  localparam logic [ADDR_W-1:0] REG_FB_DELAY = 8'h28;
  localparam logic [ADDR_W-1:0] REG_FALLBACK_FREQ = 8'h2C;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h30;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h34;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h38;

  // control register fields
  localparam int CTRL_AUX_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [1:0] FBMODE_NONE = 2'h0;
  localparam logic [1:0] FBMODE_FREEWHEEL = 2'h1;
  localparam logic [1:0] FBMODE_FIXED = 2'h2;

  // interrupt status bit positions
  localparam int IRQ_AUX_START = 0;
  localparam int IRQ_AUX_STOP = 1;
  localparam int IRQ_FB_ENTER = 2;
  localparam int IRQ_FB_LEAVE = 3;

  // reset values of the frequency registers
  localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;

  // state machines and displayed codes
  typedef enum logic [1:0] {
    AUX_OFF, AUX_START_WAIT, AUX_ON, AUX_STOP_WAIT
  } pss_aux_e;
  typedef enum logic [1:0] {FB_IDLE, FB_WAIT, FB_FALLBACK} pss_fb_e;
  typedef enum logic [1:0] {
    FAULT_NONE, FAULT_FREEWHEEL, FAULT_FIXED
  } pss_fault_e;

  // ramp command to the variable pump
  typedef struct packed {
    logic [FREQ_W-1:0] target;
    logic [TIME_W-1:0] rampTime;
  } pss_ramp_s;

endpackage

// >>> core/pss_supervisor.sv
module pss_supervisor
  import pss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [DATA_W-1:0] rdData,
  // drive inputs
  input wire logic [FREQ_W-1:0] freqRef,
  input wire logic [FREQ_W-1:0] motorFreq,
  input wire logic [FREQ_W-1:0] feedback,
  input wire logic varPumpRunning,
  // auxiliary pump and ramp
  output logic auxPumpDrivePin,
  output pss_ramp_s rampCmd,
  output logic rampLoad,
  // fallback
  output logic freewheelStop,
  output logic fixedFreqRun,
  output logic [FREQ_W-1:0] fallbackFreqOut,
  output pss_fault_e faultCode,
  // interrupt
  output logic irq
);

  // widened sum for threshold compares
  function automatic logic [FREQ_W:0] addOfs(input logic [FREQ_W-1:0] a,
                                             input logic [FREQ_W-1:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction

  // clamp a written time to the allowed range
  function automatic logic [TIME_W-1:0] clampTime(input logic [DATA_W-1:0] d);
    if (d > {16'h0000, TIME_MAX}) begin
      return TIME_MAX;
    end
    return d[TIME_W-1:0];
  endfunction

  logic withAux_r;
  logic [1:0] fbMode_r;
  logic [FREQ_W-1:0] auxStartFreq_r, auxStopFreq_r;
  logic [TIME_W-1:0] auxStartDelay_r, auxStartRamp_r;
  logic [TIME_W-1:0] auxStopDelay_r, auxStopRamp_r;
  logic [FREQ_W-1:0] topSpeed_r, topSpeedMargin_r;
  logic [FREQ_W-1:0] feedbackLowLimit_r, fallbackFrequency_r;
  logic [TIME_W-1:0] feedbackFaultDelay_r;
  logic [IRQ_W-1:0] irqStatus_r, irqMask_r, irqSet;
  logic [IRQ_W-1:0] irqClr;
  logic [31:0] tickCnt_r;
  logic tick_r;
  pss_aux_e auxState_r;
  pss_fb_e fbState_r;
  logic auxPumpDrivePin_r, rampLoad_r, irq_r;
  pss_ramp_s rampCmd_r;
  logic freewheelStop_r, fixedFreqRun_r;
  logic [FREQ_W-1:0] fallbackFreqOut_r;
  pss_fault_e faultCode_r;
  logic [DATA_W-1:0] rdData_r;
  logic freqAboveStart, freqBelowStop;
  logic fbTrip, fbStillLow, fbClear, topHit, superviseOn;
  logic startRun, stopRun, fbRun, startDone, stopDone, fbDone;
  logic wrHit;

  // register writes; delays and ramps are clamped
  always_ff @(posedge clk) begin
    if (rst) begin
      withAux_r <= 1'b0;
      fbMode_r <= FBMODE_NONE;
      auxStartFreq_r <= FREQ_RST;
      auxStopFreq_r <= FREQ_RST;
      auxStartDelay_r <= TIME_RST; // [R14]
      auxStartRamp_r <= TIME_RST;
      auxStopDelay_r <= TIME_RST;
      auxStopRamp_r <= TIME_RST;
      topSpeed_r <= FREQ_RST;
      topSpeedMargin_r <= FREQ_RST;
      feedbackLowLimit_r <= FREQ_RST;
      feedbackFaultDelay_r <= TIME_RST;
      fallbackFrequency_r <= FREQ_RST;
      irqMask_r <= '0;
    end else if (wrEn) begin
      case (addr)
        REG_CTRL: begin
          withAux_r <= wrData[CTRL_AUX_BIT]; // [R1]
          fbMode_r <= wrData[CTRL_MODE_LSB +: 2];
        end
        REG_START_FREQ: auxStartFreq_r <= wrData[FREQ_W-1:0];
        REG_STOP_FREQ: auxStopFreq_r <= wrData[FREQ_W-1:0];
        REG_START_DELAY: auxStartDelay_r <= clampTime(wrData); // [R14]
        REG_START_RAMP: auxStartRamp_r <= clampTime(wrData); // [R14]
        REG_STOP_DELAY: auxStopDelay_r <= clampTime(wrData); // [R14]
        REG_STOP_RAMP: auxStopRamp_r <= clampTime(wrData); // [R14]
        REG_TOP_SPEED: topSpeed_r <= wrData[FREQ_W-1:0];
        REG_TOP_MARGIN: topSpeedMargin_r <= wrData[FREQ_W-1:0];
        REG_FB_LIMIT: feedbackLowLimit_r <= wrData[FREQ_W-1:0];
        REG_FB_DELAY: feedbackFaultDelay_r <= clampTime(wrData);
        REG_FALLBACK_FREQ: fallbackFrequency_r <= wrData[FREQ_W-1:0];
        REG_IRQ_MASK: irqMask_r <= wrData[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (rst || !rdEn) begin
      rdData_r <= '0;
    end else begin
      case (addr)
        REG_CTRL: rdData_r <= DATA_W'({fbMode_r, withAux_r});
        REG_START_FREQ: rdData_r <= DATA_W'(auxStartFreq_r);
        REG_STOP_FREQ: rdData_r <= DATA_W'(auxStopFreq_r);
        REG_START_DELAY: rdData_r <= DATA_W'(auxStartDelay_r);
        REG_START_RAMP: rdData_r <= DATA_W'(auxStartRamp_r);
        REG_STOP_DELAY: rdData_r <= DATA_W'(auxStopDelay_r);
        REG_STOP_RAMP: rdData_r <= DATA_W'(auxStopRamp_r);
        REG_TOP_SPEED: rdData_r <= DATA_W'(topSpeed_r);
        REG_TOP_MARGIN: rdData_r <= DATA_W'(topSpeedMargin_r);
        REG_FB_LIMIT: rdData_r <= DATA_W'(feedbackLowLimit_r);
        REG_FB_DELAY: rdData_r <= DATA_W'(feedbackFaultDelay_r);
        REG_FALLBACK_FREQ: rdData_r <= DATA_W'(fallbackFrequency_r);
        REG_STATE: rdData_r <= DATA_W'({fbState_r, auxState_r,
                                        logic'(faultCode_r != FAULT_NONE),
                                        auxPumpDrivePin_r});
        REG_IRQ_STATUS: rdData_r <= DATA_W'(irqStatus_r);
        REG_IRQ_MASK: rdData_r <= DATA_W'(irqMask_r);
        default: rdData_r <= '0;
      endcase
    end
  end

  // tenth-second enable from the clock divider
  always_ff @(posedge clk) begin
    if (rst || (tickCnt_r == 32'(TICK_CYCLES - 1))) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tickCnt_r == 32'(TICK_CYCLES - 1));
    end
  end

  // threshold compares
  assign freqAboveStart = freqRef > auxStartFreq_r; // [R3]
  assign freqBelowStop = freqRef < auxStopFreq_r; // [R3]
  assign topHit = addOfs(motorFreq, topSpeedMargin_r) > {1'b0, topSpeed_r};
  assign fbTrip = addOfs(feedback, FB_TRIP_OFS) < {1'b0, feedbackLowLimit_r};
  assign fbStillLow = {1'b0, feedback} <
                      addOfs(feedbackLowLimit_r, FB_CLEAR_OFS);
  assign fbClear = {1'b0, feedback} > addOfs(feedbackLowLimit_r, FB_CLEAR_OFS);
  assign superviseOn = varPumpRunning && (fbMode_r != FBMODE_NONE) &&
                       (!withAux_r || auxPumpDrivePin_r); // [R13]

  // delay timer run conditions
  assign startRun = (auxState_r == AUX_START_WAIT) && freqAboveStart; // [R4]
  assign stopRun = (auxState_r == AUX_STOP_WAIT) && freqBelowStop; // [R6]
  assign fbRun = (fbState_r == FB_WAIT) && superviseOn && topHit &&
                 fbStillLow; // [R15]

  pss_delay_timer uStartTimer (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .run(startRun),
    .limit(auxStartDelay_r),
    .done(startDone)
  );

  pss_delay_timer uStopTimer (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .run(stopRun),
    .limit(auxStopDelay_r),
    .done(stopDone)
  );

  pss_delay_timer uFbTimer (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .run(fbRun),
    .limit(feedbackFaultDelay_r),
    .done(fbDone)
  );

  // auxiliary pump staging
  always_ff @(posedge clk) begin
    rampLoad_r <= 1'b0;
    if (rst) begin
      auxState_r <= AUX_OFF;
      auxPumpDrivePin_r <= 1'b0;
      rampCmd_r <= '0;
    end else if (!withAux_r) begin
      auxState_r <= AUX_OFF; // [R1]
      auxPumpDrivePin_r <= 1'b0;
    end else begin
      case (auxState_r)
        AUX_OFF: if (freqAboveStart) begin
          auxState_r <= AUX_START_WAIT; // [R4]
        end
        AUX_START_WAIT: if (!freqAboveStart) begin
          auxState_r <= AUX_OFF; // [R15]
        end else if (startDone) begin
          auxState_r <= AUX_ON;
          auxPumpDrivePin_r <= 1'b1; // [R2]
          rampCmd_r.target <= auxStopFreq_r; // [R5]
          rampCmd_r.rampTime <= auxStartRamp_r; // [R5]
          rampLoad_r <= 1'b1;
        end
        AUX_ON: if (freqBelowStop) begin
          auxState_r <= AUX_STOP_WAIT; // [R6]
        end
        AUX_STOP_WAIT: if (!freqBelowStop) begin
          auxState_r <= AUX_ON; // [R15]
        end else if (stopDone) begin
          auxState_r <= AUX_OFF;
          auxPumpDrivePin_r <= 1'b0; // [R2]
          rampCmd_r.target <= auxStartFreq_r; // [R7]
          rampCmd_r.rampTime <= auxStopRamp_r; // [R7]
          rampLoad_r <= 1'b1;
        end
        default: auxState_r <= AUX_OFF;
      endcase
    end
  end

  // feedback supervision and fallback
  always_ff @(posedge clk) begin
    if (rst) begin
      fbState_r <= FB_IDLE;
      freewheelStop_r <= 1'b0;
      fixedFreqRun_r <= 1'b0;
      faultCode_r <= FAULT_NONE;
      fallbackFreqOut_r <= FREQ_RST;
    end else begin
      case (fbState_r)
        FB_IDLE: if (superviseOn && topHit && fbTrip) begin
          fbState_r <= FB_WAIT; // [R8]
        end
        FB_WAIT: if (!fbRun) begin
          fbState_r <= FB_IDLE; // [R15]
        end else if (fbDone) begin
          fbState_r <= FB_FALLBACK; // [R9]
          if (fbMode_r == FBMODE_FIXED) begin
            fixedFreqRun_r <= 1'b1; // [R11]
            fallbackFreqOut_r <= fallbackFrequency_r;
            faultCode_r <= FAULT_FIXED;
          end else begin
            freewheelStop_r <= 1'b1; // [R10]
            faultCode_r <= FAULT_FREEWHEEL;
          end
        end
        FB_FALLBACK: if (fbClear) begin
          fbState_r <= FB_IDLE; // [R12]
          freewheelStop_r <= 1'b0;
          fixedFreqRun_r <= 1'b0;
          faultCode_r <= FAULT_NONE;
        end
        default: fbState_r <= FB_IDLE;
      endcase
    end
  end

  // sticky events, set wins over a write-one clear
  assign irqSet[IRQ_AUX_START] = startDone && withAux_r &&
                                 (auxState_r == AUX_START_WAIT);
  assign irqSet[IRQ_AUX_STOP] = stopDone && withAux_r &&
                                (auxState_r == AUX_STOP_WAIT);
  assign irqSet[IRQ_FB_ENTER] = (fbState_r == FB_WAIT) && fbRun && fbDone;
  assign irqSet[IRQ_FB_LEAVE] = (fbState_r == FB_FALLBACK) && fbClear;
  assign wrHit = wrEn && (addr == REG_IRQ_STATUS);
  assign irqClr = wrHit ? wrData[IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irqStatus_r <= (irqStatus_r & ~irqClr) | irqSet;
      irq_r <= |(irqStatus_r & irqMask_r);
    end
  end

  // outputs straight from flip-flops
  assign rdData = rdData_r;
  assign auxPumpDrivePin = auxPumpDrivePin_r;
  assign rampCmd = rampCmd_r;
  assign rampLoad = rampLoad_r;
  assign freewheelStop = freewheelStop_r;
  assign fixedFreqRun = fixedFreqRun_r;
  assign fallbackFreqOut = fallbackFreqOut_r;
  assign faultCode = faultCode_r;
  assign irq = irq_r;

  // checks on the staging and supervision behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sStartIssue;
    (auxState_r == AUX_START_WAIT) && freqAboveStart && startDone &&
      withAux_r;
  endsequence

  sequence sStopIssue;
    (auxState_r == AUX_STOP_WAIT) && freqBelowStop && stopDone && withAux_r;
  endsequence

  a_start_ramp_cmd: assert property ( // [R5]
    sStartIssue |=> auxPumpDrivePin_r && rampLoad_r &&
      (rampCmd_r.target == $past(auxStopFreq_r)) &&
      (rampCmd_r.rampTime == $past(auxStartRamp_r)))
    else $error("start ramp command wrong");

  a_stop_ramp_cmd: assert property ( // [R7]
    sStopIssue |=> !auxPumpDrivePin_r && rampLoad_r &&
      (rampCmd_r.target == $past(auxStartFreq_r)) &&
      (rampCmd_r.rampTime == $past(auxStopRamp_r)))
    else $error("stop ramp command wrong");

  a_start_needs_high: assert property ( // [R4]
    $rose(auxPumpDrivePin_r) |-> $past(freqAboveStart) &&
      ($past(auxState_r) == AUX_START_WAIT))
    else $error("auxiliary pump started without delay");

  a_stop_needs_low: assert property ( // [R6]
    $fell(auxPumpDrivePin_r) && $past(withAux_r) |->
      $past(freqBelowStop) && ($past(auxState_r) == AUX_STOP_WAIT))
    else $error("auxiliary pump stopped without delay");

  a_single_mode_off: assert property ( // [R1]
    !withAux_r |=> !auxPumpDrivePin_r && (auxState_r == AUX_OFF))
    else $error("auxiliary pump active in single mode");

  a_fallback_code: assert property ( // [R10]
    (fbState_r == FB_WAIT) && fbRun && fbDone |=>
      (fixedFreqRun_r ? (faultCode_r == FAULT_FIXED) :
       (freewheelStop_r && (faultCode_r == FAULT_FREEWHEEL))))
    else $error("fallback entered with wrong code");

  a_fixed_freq_out: assert property ( // [R11]
    $rose(fixedFreqRun_r) |-> (fallbackFreqOut_r == $past(fallbackFrequency_r))
      && !freewheelStop_r)
    else $error("fixed fallback frequency wrong");

  a_fallback_exit: assert property ( // [R12]
    (fbState_r == FB_FALLBACK) && fbClear |=>
      !freewheelStop_r && !fixedFreqRun_r && (faultCode_r == FAULT_NONE))
    else $error("fallback not left on recovered feedback");

  a_supervise_gate: assert property ( // [R13]
    (fbState_r == FB_IDLE) && withAux_r && !auxPumpDrivePin_r |=>
      (fbState_r == FB_IDLE))
    else $error("supervision armed with auxiliary pump off");

  a_delay_range: assert property ( // [R14]
    (auxStartDelay_r <= TIME_MAX) && (auxStopDelay_r <= TIME_MAX) &&
      (auxStartRamp_r <= TIME_MAX) && (auxStopRamp_r <= TIME_MAX))
    else $error("delay or ramp above range");

  a_irq_level: assert property (
    ##1 (irq_r == |($past(irqStatus_r) & $past(irqMask_r))))
    else $error("interrupt level wrong");

endmodule // pss_supervisor

// >>> verification/pss_pump_model.sv
module pss_pump_model
  import pss_pkg::*;
#(
  parameter int SPINUP = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commands from the drive
  input wire logic auxPumpDrivePin,
  input wire logic freewheelStop,
  // bench demand
  input wire logic runCmd,
  input wire logic [FREQ_W-1:0] pressureSet,
  // pump and sensor state
  output logic auxRunning,
  output logic varPumpRunning,
  output logic [FREQ_W-1:0] feedback
);
  timeunit 1ns;
  timeprecision 1ps;

  int spin;

  // aux pump spins up a few cycles after the pin rises, stops at once
  always_ff @(posedge clk) begin
    if (rst || !auxPumpDrivePin) begin
      spin <= 0;
      auxRunning <= 1'b0;
    end else if (spin < SPINUP) begin
      spin <= spin + 1;
    end else begin
      auxRunning <= 1'b1;
    end
  end

  // coasting motor no longer reports running
  always_ff @(posedge clk) begin
    varPumpRunning <= !rst && runCmd && !freewheelStop;
  end

  // sensor reading lags the demanded pressure by one cycle
  always_ff @(posedge clk) begin
    feedback <= rst ? 16'h0000 : pressureSet;
  end
endmodule // pss_pump_model

// >>> verification/tb_top.sv
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module tb_top
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] START_F = 16'h01EA;
  localparam logic [15:0] STOP_F = 16'h018C;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wrData = '0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic [FREQ_W-1:0] freqRef = '0;
  logic [FREQ_W-1:0] motorFreq = '0;
  logic [FREQ_W-1:0] feedback;
  logic [FREQ_W-1:0] pressureSet = 16'h03E8;
  logic varPumpRunning;
  logic runCmd = 1'b1;
  logic auxRunning;
  logic auxPumpDrivePin;
  pss_ramp_s rampCmd;
  logic rampLoad;
  logic freewheelStop;
  logic fixedFreqRun;
  logic [FREQ_W-1:0] fallbackFreqOut;
  pss_fault_e faultCode;
  logic irq;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic [DATA_W-1:0] d;
  logic [31:0] expRamp;
  logic [31:0] rampQ[$];
  logic [ADDR_W-1:0] cfgA[12] = '{REG_CTRL, REG_START_FREQ, REG_STOP_FREQ,
    REG_START_DELAY, REG_START_RAMP, REG_STOP_DELAY, REG_STOP_RAMP,
    REG_TOP_SPEED, REG_TOP_MARGIN, REG_FB_LIMIT, REG_FB_DELAY,
    REG_FALLBACK_FREQ};
  logic [15:0] cfgV[12] = '{16'h0003, START_F, STOP_F, 16'h0002, 16'h000A,
    16'h0002, 16'h000F, 16'h0258, 16'h000A, 16'h00AA, 16'h0001, 16'h01F4};

  // design and far-side model
  pss_supervisor #(.TICK_CYCLES(4)) u_pss_supervisor (.clk(clk), .rst(rst),
    .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .freqRef(freqRef), .motorFreq(motorFreq), .feedback(feedback),
    .varPumpRunning(varPumpRunning), .auxPumpDrivePin(auxPumpDrivePin),
    .rampCmd(rampCmd), .rampLoad(rampLoad), .freewheelStop(freewheelStop),
    .fixedFreqRun(fixedFreqRun), .fallbackFreqOut(fallbackFreqOut),
    .faultCode(faultCode), .irq(irq));
  pss_pump_model u_pss_pump_model (.clk(clk), .rst(rst),
    .auxPumpDrivePin(auxPumpDrivePin), .freewheelStop(freewheelStop),
    .runCmd(runCmd), .pressureSet(pressureSet), .auxRunning(auxRunning),
    .varPumpRunning(varPumpRunning), .feedback(feedback));

  // clock
  always #20 clk = ~clk;

  task automatic results;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  // every ramp load must match the next predicted command
  always @(posedge clk) begin
    if (!rst && rampLoad === 1'b1) begin
      if (rampQ.size() == 0) begin
        `CHK("rampLoad", 1'b0, rampLoad)
      end else begin
        expRamp = rampQ.pop_front();
        `CHK("rampCmd", expRamp, rampCmd)
      end
    end
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 v = rdData;
  endtask

  function automatic logic outSel(input int w);
    case (w)
      0: return auxPumpDrivePin;
      1: return freewheelStop;
      default: return fixedFreqRun;
    endcase
  endfunction

  // counts edges until the chosen output reaches v, bounded
  task automatic waitOut(input int w, input logic v, output int k);
    k = 0;
    while (outSel(w) !== v && k < 40) begin
      @(posedge clk);
      #1 k++;
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hD488));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(REG_START_DELAY, d);
    `CHK("startDelayRst", 32'h0000_0014, d)
    rd(REG_STOP_RAMP, d);
    `CHK("stopRampRst", 32'h0000_0014, d)
    rd(8'h3C, d);
    `CHK("unmapped", 32'h0000_0000, d)
    wr(REG_START_DELAY, 32'h0001_0000);
    rd(REG_START_DELAY, d);
    `CHK("delayClamp", 32'h0000_270F, d)
    foreach (cfgA[i]) wr(cfgA[i], {16'h0000, cfgV[i]});
    wr(REG_IRQ_MASK, 32'h0000_0001);
    // a short excursion above the start level is cancelled
    @(posedge clk) freqRef <= START_F + 16'(1 + $urandom % 50);
    @(posedge clk);
    @(posedge clk);
    @(posedge clk) freqRef <= 16'h01C2;
    settle(20);
    `CHK("pinLapse", 1'b0, auxPumpDrivePin)
    rampQ.push_back({STOP_F, 16'h000A});
    @(posedge clk) freqRef <= START_F + 16'(1 + $urandom % 50);
    waitOut(0, 1'b1, n);
    `CHK("startTime", 1'b1, n >= 7 && n <= 10)
    `CHK("startLoad", 1'b1, rampLoad)
    settle(2);
    `CHK("irqStart", 1'b1, irq)
    wr(REG_IRQ_STATUS, 32'h0000_0001);
    settle(2);
    `CHK("irqClear", 1'b0, irq)
    // inside the hysteresis band nothing changes
    @(posedge clk) freqRef <= 16'h01C2;
    settle(24);
    `CHK("pinBand", 1'b1, auxPumpDrivePin)
    rd(REG_STATE, d);
    `CHK("stateOn", 32'h0000_0009, d)
    // feedback collapse at top speed with both pumps on
    @(posedge clk) motorFreq <= 16'h0258;
    pressureSet <= 16'h0064;
    waitOut(1, 1'b1, n);
    `CHK("fbTripTime", 1'b1, n >= 4 && n < 40)
    `CHK("fbCode", FAULT_FREEWHEEL, faultCode)
    @(posedge clk) pressureSet <= 16'h00C8;
    settle(6);
    `CHK("fbHold", 1'b1, freewheelStop)
    @(posedge clk) pressureSet <= 16'h00C9;
    settle(3);
    `CHK("fbLeave", 1'b0, freewheelStop)
    `CHK("fbCodeClr", FAULT_NONE, faultCode)
    rd(REG_IRQ_STATUS, d);
    `CHK("irqStatus", 32'h0000_000C, d)
    wr(REG_IRQ_STATUS, 32'h0000_000F);
    // drop below the stop level
    rampQ.push_back({START_F, 16'h000F});
    @(posedge clk) freqRef <= STOP_F - 16'(1 + $urandom % 50);
    waitOut(0, 1'b0, n);
    `CHK("stopTime", 1'b1, n >= 7 && n <= 10)
    `CHK("stopLoad", 1'b1, rampLoad)
    // aux pump off: supervision stays quiet
    @(posedge clk) pressureSet <= 16'h0064;
    settle(40);
    `CHK("noSuperv", 1'b0, freewheelStop | fixedFreqRun)
    // single pump mode with fixed-frequency fallback
    wr(REG_CTRL, 32'h0000_0004);
    waitOut(2, 1'b1, n);
    `CHK("fixedRun", 1'b1, fixedFreqRun)
    `CHK("fixedFreq", 16'h01F4, fallbackFreqOut)
    `CHK("fixedCode", FAULT_FIXED, faultCode)
    `CHK("fixedCoast", 1'b0, freewheelStop)
    `CHK("irqMasked", 1'b0, irq)
    wr(REG_IRQ_MASK, 32'h0000_0004);
    settle(2);
    `CHK("irqEnter", 1'b1, irq)
    @(posedge clk) pressureSet <= 16'h012C;
    settle(3);
    `CHK("fixedLeave", 1'b0, fixedFreqRun)
    @(posedge clk) freqRef <= 16'h0258;
    settle(40);
    `CHK("singlePin", 1'b0, auxPumpDrivePin)
    `CHK("rampLeft", 0, rampQ.size())
    results();
  end
endmodule // tb_top
